// file: ldps_top.sv
// Protection sequencer of a constant-current laser driver with an AXI4-Lite register port.
`default_nettype none

module ldps_top #(
  parameter int SOFT_START_CYC = ldps_pkg::SOFT_START_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        enable_pin,
  input  wire logic        interlock_pin,
  input  wire logic        overcurrent_pin,
  input  wire logic [7:0]  board_temp,
  input  wire logic [7:0]  thermistor_temp,
  input  wire logic [15:0] analog_iset,
  output var  logic [15:0] drive_level,
  output var  logic        regulation_on,
  output var  logic        crowbar_status,
  output var  logic        overtemp_warning
);

  // ========================================================================
  // State
  typedef struct packed {
    logic                en_s1;
    logic                en_s2;
    logic                ilk_s1;
    logic                ilk_s2;
    logic                oc_s1;
    logic                oc_s2;
    logic [7:0]          bt_s1;
    logic [7:0]          bt_s2;
    logic [7:0]          nt_s1;
    logic [7:0]          nt_s2;
    logic [15:0]         ai_s1;
    logic [15:0]         ai_s2;
    logic [3:0]          ctrl;
    logic [15:0]         iset;
    logic [7:0]          tlo;
    logic [7:0]          thi;
    ldps_pkg::ldps_state_e st;
    logic                oc_lat;
    logic                ot_stop;
    logic                warn;
    logic                reg_on;
    logic                crowbar;
    logic                aw_have;
    logic [4:0]          aw_addr;
    logic                w_have;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                aw_rdy;
    logic                w_rdy;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                ar_rdy;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } ldps_top_s;

  localparam ldps_top_s S_RST = '{
    ilk_s1: 1'b1, ilk_s2: 1'b1, st: ldps_pkg::ST_OFF,
    ctrl: ldps_pkg::CTRL_RST, iset: ldps_pkg::ISET_RST,
    tlo: ldps_pkg::TLO_RST, thi: ldps_pkg::THI_RST,
    aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};

  ldps_top_s   s_r;
  ldps_top_s   s_nxt;
  logic        en_eff;
  logic        ilk_ok;
  logic        ntc_ok;
  logic        run_req;
  logic        trip;
  logic        ramp_done;
  logic [15:0] target;
  logic [2:0]  widx;
  logic [2:0]  ridx;
  logic [31:0] stat_w;
  logic [31:0] wm;

  // ========================================================================
  // Decoding helpers
  // Maps a byte address to a register index.
  function automatic logic [2:0] reg_idx(input logic [4:0] a);
    logic [2:0] r;
    case (a)
      ldps_pkg::OFF_CTRL: r = ldps_pkg::IDX_CTRL;
      ldps_pkg::OFF_ISET: r = ldps_pkg::IDX_ISET;
      ldps_pkg::OFF_TLIM: r = ldps_pkg::IDX_TLIM;
      ldps_pkg::OFF_STAT: r = ldps_pkg::IDX_STAT;
      ldps_pkg::OFF_TEMP: r = ldps_pkg::IDX_TEMP;
      default:            r = ldps_pkg::IDX_NONE;
    endcase
    return r;
  endfunction

  // Selects the readback word of a register index.
  function automatic logic [31:0] pick(input logic [2:0] i, input ldps_top_s s,
                                       input logic [31:0] st_w);
    logic [31:0] r;
    case (i)
      ldps_pkg::IDX_CTRL: r = {28'h0000000, s.ctrl};
      ldps_pkg::IDX_ISET: r = {16'h0000, s.iset};
      ldps_pkg::IDX_TLIM: r = {16'h0000, s.thi, s.tlo};
      ldps_pkg::IDX_STAT: r = st_w;
      ldps_pkg::IDX_TEMP: r = {16'h0000, s.nt_s2, s.bt_s2};
      default:            r = 32'h00000000;
    endcase
    return r;
  endfunction

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) begin
        r[8*k +: 8] = d[8*k +: 8];
      end
    end
    return r;
  endfunction

  // ========================================================================
  // Run conditions
  // Selects enable source, interlock and thermistor window.
  assign en_eff  = s_r.ctrl[ldps_pkg::CTRL_INT_EN] ? s_r.ctrl[ldps_pkg::CTRL_SW_START]
                                                  : s_r.en_s2;
  assign ilk_ok  = s_r.ctrl[ldps_pkg::CTRL_DENY_ILK] | ~s_r.ilk_s2;
  assign ntc_ok  = (s_r.nt_s2 >= s_r.tlo) && (s_r.nt_s2 <= s_r.thi);
  assign run_req = en_eff & ilk_ok & ntc_ok;
  assign trip    = s_r.oc_lat | s_r.ot_stop;
  assign target  = s_r.ctrl[ldps_pkg::CTRL_INT_ISET] ? s_r.iset : s_r.ai_s2;
  assign widx    = reg_idx(s_r.aw_addr);
  assign ridx    = reg_idx(araddr);

  // Gathers the live status word.
  always_comb begin
    stat_w                          = 32'h00000000;
    stat_w[ldps_pkg::STAT_REG_ON]   = s_r.reg_on;
    stat_w[ldps_pkg::STAT_RAMPING]  = (s_r.st == ldps_pkg::ST_RAMP);
    stat_w[ldps_pkg::STAT_OC_FAULT] = s_r.oc_lat;
    stat_w[ldps_pkg::STAT_OT_STOP]  = s_r.ot_stop;
    stat_w[ldps_pkg::STAT_WARN]     = s_r.warn;
    stat_w[ldps_pkg::STAT_NTC_BLK]  = ~ntc_ok;
    stat_w[ldps_pkg::STAT_ILK_OPEN] = s_r.ilk_s2;
    stat_w[ldps_pkg::STAT_EN_EFF]   = en_eff;
    stat_w[ldps_pkg::STAT_STATE +: 4] = s_r.st;
  end

  // ========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    wm    = merge(pick(widx, s_r, stat_w), s_r.w_data, s_r.w_strb);
    // Two-stage synchronisers for every pin input.
    s_nxt.en_s1  = enable_pin;
    s_nxt.en_s2  = s_r.en_s1;
    s_nxt.ilk_s1 = interlock_pin;
    s_nxt.ilk_s2 = s_r.ilk_s1;
    s_nxt.oc_s1  = overcurrent_pin;
    s_nxt.oc_s2  = s_r.oc_s1;
    s_nxt.bt_s1  = board_temp;
    s_nxt.bt_s2  = s_r.bt_s1;
    s_nxt.nt_s1  = thermistor_temp;
    s_nxt.nt_s2  = s_r.nt_s1;
    s_nxt.ai_s1  = analog_iset;
    s_nxt.ai_s2  = s_r.ai_s1;

    // Protection flags; the over-current latch has no clear but reset.
    s_nxt.oc_lat = s_r.oc_lat | s_r.oc_s2;
    if (s_r.bt_s2 > ldps_pkg::STOP_C) begin
      s_nxt.ot_stop = 1'b1;
    end else if (s_r.bt_s2 <= ldps_pkg::RESUME_C) begin
      s_nxt.ot_stop = 1'b0;
    end
    if (s_r.bt_s2 > ldps_pkg::WARN_SET_C) begin
      s_nxt.warn = 1'b1;
    end else if (s_r.bt_s2 < ldps_pkg::RESUME_C) begin
      s_nxt.warn = 1'b0;
    end

    // Sequencer; a trip overrides every request.
    case (s_r.st)
      ldps_pkg::ST_OFF: begin
        if (trip) begin
          s_nxt.st = ldps_pkg::ST_TRIP;
        end else if (run_req) begin
          s_nxt.st = ldps_pkg::ST_RAMP;
        end
      end
      ldps_pkg::ST_RAMP: begin
        if (trip) begin
          s_nxt.st = ldps_pkg::ST_TRIP;
        end else if (!run_req) begin
          s_nxt.st = ldps_pkg::ST_OFF;
        end else if (ramp_done) begin
          s_nxt.st = ldps_pkg::ST_ON;
        end
      end
      ldps_pkg::ST_ON: begin
        if (trip) begin
          s_nxt.st = ldps_pkg::ST_TRIP;
        end else if (!run_req) begin
          s_nxt.st = ldps_pkg::ST_OFF;
        end
      end
      ldps_pkg::ST_TRIP: begin
        if (!trip) begin
          s_nxt.st = ldps_pkg::ST_OFF;
        end
      end
      default: begin
        s_nxt.st = ldps_pkg::ST_TRIP;
      end
    endcase
    s_nxt.reg_on  = (s_nxt.st == ldps_pkg::ST_RAMP) || (s_nxt.st == ldps_pkg::ST_ON);
    s_nxt.crowbar = s_nxt.oc_lat | s_nxt.ot_stop;

    // Write channel: address and data are taken in either order.
    if (awvalid && s_r.aw_rdy) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.w_rdy) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = ldps_pkg::RESP_OKAY;
      case (widx)
        ldps_pkg::IDX_CTRL: s_nxt.ctrl = wm[3:0];
        ldps_pkg::IDX_ISET: s_nxt.iset = wm[15:0];
        ldps_pkg::IDX_TLIM: begin
          s_nxt.tlo = wm[7:0];
          s_nxt.thi = wm[15:8];
        end
        ldps_pkg::IDX_STAT, ldps_pkg::IDX_TEMP: begin
          s_nxt.bresp = ldps_pkg::RESP_OKAY;
        end
        default: s_nxt.bresp = ldps_pkg::RESP_SLVERR;
      endcase
    end
    s_nxt.aw_rdy = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.w_rdy  = !s_nxt.w_have && !s_nxt.bvalid;

    // Read channel: one outstanding read, answered the next cycle.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.ar_rdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = pick(ridx, s_r, stat_w);
      s_nxt.rresp  = (ridx == ldps_pkg::IDX_NONE) ? ldps_pkg::RESP_SLVERR
                                                  : ldps_pkg::RESP_OKAY;
    end
    s_nxt.ar_rdy = !s_nxt.rvalid;
  end

  // Registers the whole state; reset is the power-up default.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Soft-start ramp
  ldps_ramp #(
    .TICK_CYC (SOFT_START_CYC / ldps_pkg::RAMP_STEPS)
  ) u_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (s_r.reg_on),
    .target  (target),
    .level   (drive_level),
    .done    (ramp_done)
  );

  // Output assignments from registers.
  assign awready          = s_r.aw_rdy;
  assign wready           = s_r.w_rdy;
  assign bvalid           = s_r.bvalid;
  assign bresp            = s_r.bresp;
  assign arready          = s_r.ar_rdy;
  assign rvalid           = s_r.rvalid;
  assign rdata            = s_r.rdata;
  assign rresp            = s_r.rresp;
  assign regulation_on    = s_r.reg_on;
  assign crowbar_status   = s_r.crowbar;
  assign overtemp_warning = s_r.warn;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_run_off;
    (s_r.st == ldps_pkg::ST_ON) && !run_req |=> !regulation_on;
  endproperty
  a_run_off: assert property (p_run_off) else $error("output not stopped");

  property p_ramp_zero;
    $rose(regulation_on) |-> drive_level == 16'h0000 ##1 !ramp_done;
  endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("ramp not from zero");

  property p_pulse_follow;
    (s_r.st == ldps_pkg::ST_OFF) && run_req && !trip |=> regulation_on;
  endproperty
  a_pulse_follow: assert property (p_pulse_follow) else $error("pulse missed");

  property p_trip_clamp;
    s_r.oc_lat || (s_r.ot_stop && (s_r.bt_s2 > ldps_pkg::RESUME_C))
      |=> !regulation_on && crowbar_status;
  endproperty
  a_trip_clamp: assert property (p_trip_clamp) else $error("no clamp on trip");

  property p_trip_hold;
    (s_r.st == ldps_pkg::ST_TRIP) && trip |=> (s_r.st == ldps_pkg::ST_TRIP);
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("enable not ignored");

  property p_fault_latch;
    s_r.oc_lat |=> s_r.oc_lat [*8];
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault cleared");

  property p_status_pin;
    crowbar_status == (s_r.oc_lat || s_r.ot_stop);
  endproperty
  a_status_pin: assert property (p_status_pin) else $error("status wrong");

  property p_interlock;
    !ilk_ok |=> !regulation_on;
  endproperty
  a_interlock: assert property (p_interlock) else $error("interlock open");

  property p_warn_hyst;
    (s_r.bt_s2 > ldps_pkg::WARN_SET_C |=> overtemp_warning) and
    (s_r.bt_s2 < ldps_pkg::RESUME_C |=> !overtemp_warning);
  endproperty
  a_warn_hyst: assert property (p_warn_hyst) else $error("warning wrong");

  property p_thermal;
    s_r.ot_stop && (s_r.bt_s2 > ldps_pkg::RESUME_C) |=> s_r.ot_stop ##1 !regulation_on;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal restart early");

  property p_ntc_block;
    !ntc_ok |=> !regulation_on;
  endproperty
  a_ntc_block: assert property (p_ntc_block) else $error("thermistor block");

  property p_power_up;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> s_r.ctrl == ldps_pkg::CTRL_RST && !s_r.oc_lat;
  endproperty
  a_power_up: assert property (p_power_up) else $error("power-up state");

  property p_sw_stop;
    s_r.ctrl[ldps_pkg::CTRL_INT_EN] && !s_r.ctrl[ldps_pkg::CTRL_SW_START]
      |=> !regulation_on;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("software stop");

  c_on:    cover property ($rose(s_r.st == ldps_pkg::ST_ON));
  c_trip:  cover property ($rose(s_r.st == ldps_pkg::ST_TRIP));
  c_pulse: cover property ($fell(regulation_on) ##[1:40] $rose(regulation_on));
  c_ntc:   cover property ($fell(ntc_ok));
endmodule

`default_nettype wire

// file: ldps_ramp.sv
// Shared constants of the laser driver protection sequencer and its soft-start ramp.
`default_nettype none

// ==========================================================================
// Package
package ldps_pkg;
  // Clock and soft-start timing.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SOFT_START_US   = 400;
  localparam int SOFT_START_CYC  = SOFT_START_US * 1000 / CLK_PERIOD_NS;
  localparam int RAMP_STEPS      = 256;
  // Register byte offsets and decoded indices.
  localparam int          AXI_AW   = 5;
  localparam logic [4:0]  OFF_CTRL = 5'h00;
  localparam logic [4:0]  OFF_ISET = 5'h04;
  localparam logic [4:0]  OFF_TLIM = 5'h08;
  localparam logic [4:0]  OFF_STAT = 5'h0C;
  localparam logic [4:0]  OFF_TEMP = 5'h10;
  localparam logic [2:0]  IDX_CTRL = 3'h0;
  localparam logic [2:0]  IDX_ISET = 3'h1;
  localparam logic [2:0]  IDX_TLIM = 3'h2;
  localparam logic [2:0]  IDX_STAT = 3'h3;
  localparam logic [2:0]  IDX_TEMP = 3'h4;
  localparam logic [2:0]  IDX_NONE = 3'h7;
  // Control register fields.
  localparam int CTRL_INT_EN   = 0;
  localparam int CTRL_SW_START = 1;
  localparam int CTRL_DENY_ILK = 2;
  localparam int CTRL_INT_ISET = 3;
  // Status register fields.
  localparam int STAT_REG_ON   = 0;
  localparam int STAT_RAMPING  = 1;
  localparam int STAT_OC_FAULT = 2;
  localparam int STAT_OT_STOP  = 3;
  localparam int STAT_WARN     = 4;
  localparam int STAT_NTC_BLK  = 5;
  localparam int STAT_ILK_OPEN = 6;
  localparam int STAT_EN_EFF   = 7;
  localparam int STAT_STATE    = 8;
  // Reset values.
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [15:0] ISET_RST = 16'h0000;
  localparam logic [7:0]  TLO_RST  = 8'h00;
  localparam logic [7:0]  THI_RST  = 8'hFF;
  // Board temperature thresholds in whole degrees C: 60, 58, 80.
  localparam logic [7:0]  WARN_SET_C = 8'h3C;
  localparam logic [7:0]  RESUME_C   = 8'h3A;
  localparam logic [7:0]  STOP_C     = 8'h50;
  // Bus responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Sequencer states.
  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_RAMP = 4'h2,
    ST_ON   = 4'h4,
    ST_TRIP = 4'h8
  } ldps_state_e;
endpackage

// ==========================================================================
// Soft-start ramp
module ldps_ramp #(
  parameter int TICK_CYC = 156
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic [15:0] target,
  output var  logic [15:0] level,
  output var  logic        done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [8:0]  frac;
    logic [15:0] level;
    logic        done;
  } ldps_ramp_s;

  ldps_ramp_s r_r;
  ldps_ramp_s r_nxt;
  logic [24:0] prod;

  // Steps the fraction from 0 to 1 and scales the target by it; stop drops to zero.
  always_comb begin
    r_nxt = r_r;
    prod  = 25'h0000000;
    if (!run) begin
      r_nxt = '0;
    end else begin
      if (r_r.cnt == 16'(TICK_CYC - 1)) begin
        r_nxt.cnt = 16'h0000;
        if (r_r.frac != 9'(ldps_pkg::RAMP_STEPS)) begin
          r_nxt.frac = r_r.frac + 9'h001;
        end
      end else begin
        r_nxt.cnt = r_r.cnt + 16'h0001;
      end
      prod        = 25'(target * r_r.frac);
      r_nxt.level = prod[23:8];
      r_nxt.done  = (r_r.frac == 9'(ldps_pkg::RAMP_STEPS));
    end
  end

  // Registers the ramp state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign level = r_r.level;
  assign done  = r_r.done;
endmodule

`default_nettype wire

// file: ldps_ctl_model.sv
// Controller model that drives the enable and interlock lines of the sequencer.
`default_nettype none

// ==========================================================================
// Controller model
module ldps_ctl_model (
  input  wire logic aclk,
  input  wire logic en_req,
  input  wire logic ilk_open,
  input  wire logic pulse_on,
  output var  logic enable_pin,
  output var  logic interlock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ph_r;

  // Lines start as an unconnected controller leaves them: enable low, interlock open.
  initial begin
    ph_r = 6'h00;
    enable_pin = 1'b0;
    interlock_pin = 1'b1;
  end

  // Enable follows the request or a square wave of 32 cycles high and 32 low.
  always @(posedge aclk) begin
    ph_r <= ph_r + 6'h01;
    enable_pin <= pulse_on ? ph_r[5] : en_req;
    interlock_pin <= ilk_open;
  end
endmodule

`default_nettype wire

// file: ldps_top_tb.sv
// Self-checking bench of the laser driver protection sequencer.
`default_nettype none

// ==========================================================================
// Bench
module ldps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, enable_pin, interlock_pin;
  logic        overcurrent_pin = 1'b0, en_req = 1'b0, ilk_open = 1'b1, pulse_on = 1'b0;
  logic        regulation_on, crowbar_status, overtemp_warning, prev;
  logic [7:0]  board_temp = 8'h28, thermistor_temp = 8'h28;
  logic [15:0] analog_iset = 16'h1000, drive_level;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          miscompares = 0, num_checks = 0, seed = 70889, rises, i;

  ldps_top #(.SOFT_START_CYC(512)) ldps_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .enable_pin, .interlock_pin, .overcurrent_pin,
    .board_temp, .thermistor_temp, .analog_iset, .drive_level, .regulation_on,
    .crowbar_status, .overtemp_warning);
  ldps_ctl_model ldps_ctl_model_i (.aclk, .en_req, .ilk_open, .pulse_on, .enable_pin,
    .interlock_pin);

  // Clock of 100 MHz.
  always #5 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits a bounded time for a level; a wait that runs out ends the run.
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int k = 0; k < n && s !== v; k++) @(posedge aclk);
    chk(s, v);
    if (s !== v) stop_test();
  endtask

  task automatic hold(ref logic s, input logic v, input int n);
    repeat (n) begin
      @(posedge aclk);
      chk(s, v);
    end
  endtask

  // Bus master: hold each channel until taken, then wait for the answer.
  task automatic bus_wait(input logic is_wr);
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      k++;
    end while (!(is_wr ? bvalid && bready : rvalid && rready) && k < 50);
    bready <= 1'b0;
    rready <= 1'b0;
    if (k >= 50) chk(1'b0, 1'b1);
    if (k >= 50) stop_test();
    // One idle edge so that a following request never reassigns a handshake in this step.
    @(posedge aclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bus_wait(1'b1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    bus_wait(1'b0);
  endtask

  // Answers are matched to the oldest note; the level never overshoots its target.
  always @(posedge aclk) begin
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (drive_level > analog_iset) chk(drive_level, analog_iset);
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    analog_iset <= {8'($random(seed)) | 8'h01, 8'h00};
    chk({awready, wready, arready, regulation_on, crowbar_status, overtemp_warning,
         drive_level}, 22'h380000);
    rd(ldps_pkg::OFF_CTRL, 34'h0);
    rd(ldps_pkg::OFF_TLIM, 34'h0_0000_FF00);
    rd(5'h14, {ldps_pkg::RESP_SLVERR, 32'h0});
    wr(5'h14, 32'h1, ldps_pkg::RESP_SLVERR);
    wr(ldps_pkg::OFF_TEMP, 32'hFFFF, ldps_pkg::RESP_OKAY);
    rd(ldps_pkg::OFF_TEMP, 34'h0_0000_2828);
    en_req <= 1'b1;
    hold(regulation_on, 1'b0, 10);
    ilk_open <= 1'b0;
    wait_for(regulation_on, 1'b1, 8);
    chk(drive_level < analog_iset, 1'b1);
    for (i = 0; i < 1200 && drive_level !== analog_iset; i++) @(posedge aclk);
    chk(drive_level, analog_iset);
    ilk_open <= 1'b1;
    wait_for(regulation_on, 1'b0, 8);
    ilk_open <= 1'b0;
    wait_for(regulation_on, 1'b1, 8);
    chk(drive_level < analog_iset, 1'b1);
    pulse_on <= 1'b1;
    rises = 0;
    prev = 1'b1;
    repeat (320) begin
      @(posedge aclk);
      rises += int'(regulation_on && !prev);
      prev = regulation_on;
    end
    chk(rises >= 4, 1'b1);
    pulse_on <= 1'b0;
    wait_for(regulation_on, 1'b1, 8);
    board_temp <= 8'h3D;
    wait_for(overtemp_warning, 1'b1, 6);
    board_temp <= 8'h3B;
    hold(overtemp_warning, 1'b1, 10);
    board_temp <= 8'h39;
    wait_for(overtemp_warning, 1'b0, 6);
    board_temp <= 8'h51;
    wait_for(regulation_on, 1'b0, 8);
    chk(crowbar_status, 1'b1);
    board_temp <= 8'h3B;
    hold(regulation_on, 1'b0, 20);
    board_temp <= 8'h3A;
    wait_for(regulation_on, 1'b1, 10);
    wr(ldps_pkg::OFF_TLIM, 32'h3020, ldps_pkg::RESP_OKAY);
    thermistor_temp <= 8'h31;
    wait_for(regulation_on, 1'b0, 8);
    thermistor_temp <= 8'h30;
    wait_for(regulation_on, 1'b1, 8);
    rd(ldps_pkg::OFF_TEMP, 34'h0_0000_303A);
    wr(ldps_pkg::OFF_CTRL, 32'h1, ldps_pkg::RESP_OKAY);
    wait_for(regulation_on, 1'b0, 8);
    wr(ldps_pkg::OFF_CTRL, 32'h7, ldps_pkg::RESP_OKAY);
    wait_for(regulation_on, 1'b1, 8);
    ilk_open <= 1'b1;
    hold(regulation_on, 1'b1, 10);
    rd(ldps_pkg::OFF_CTRL, 34'h7);
    ilk_open <= 1'b0;
    wr(ldps_pkg::OFF_CTRL, 32'h0, ldps_pkg::RESP_OKAY);
    overcurrent_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    overcurrent_pin <= 1'b0;
    wait_for(crowbar_status, 1'b1, 8);
    wait_for(regulation_on, 1'b0, 8);
    pulse_on <= 1'b1;
    hold(regulation_on, 1'b0, 150);
    chk({crowbar_status, drive_level}, 17'h10000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    pulse_on <= 1'b0;
    wait_for(crowbar_status, 1'b0, 4);
    wait_for(regulation_on, 1'b1, 10);
    stop_test();
  end
endmodule

`default_nettype wire
